/* File: hw/word_logic_shift_cfg.svh */
// Constants of the word logic and shift unit: APB offsets, field positions,
// operand widths and reset values.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef WORD_LOGIC_SHIFT_CFG_SVH
`define WORD_LOGIC_SHIFT_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WLS_ADDR_W 12
`define WLS_OFF_FIRST 12'h000
`define WLS_OFF_SECOND 12'h004
`define WLS_OFF_COUNT 12'h008
`define WLS_OFF_CTRL 12'h00C
`define WLS_OFF_RESULT 12'h010
`define WLS_OFF_STATUS 12'h014

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WLS_CTRL_OP_LSB 0
`define WLS_CTRL_OP_W 3
`define WLS_CTRL_EXEC_BIT 8
`define WLS_ST_CASCADE_BIT 0
`define WLS_ST_ZERO_BIT 1
`define WLS_ST_NONZERO_BIT 2
`define WLS_ST_TOO_LARGE_BIT 3
`define WLS_ST_LOGIC_BIT 4

// ----------------------------------------------------------------------
// Widths, limits and reset values
// ----------------------------------------------------------------------
`define WLS_DATA_W 32
`define WLS_COUNT_W 16
`define WLS_WORD_BITS 16'h0010
`define WLS_DWORD_BITS 16'h0020
`define WLS_WORD_CLAMP 5'h10
`define WLS_RESET_WORD 32'h0000_0000
`define WLS_RESET_COUNT 16'h0000

`endif

/* File: hw/word_logic_shift_pkg.sv */
// Types shared by the word logic and shift unit.
// Assumes nothing beyond the constants header.
package word_logic_shift_pkg;

    // Operation selector; codes beyond the last entry are refused
    typedef enum logic [2:0] {
        OP_DWORD_EXCLUSIVE_COMBINE,
        OP_WORD_LEFT_SHIFT,
        OP_DWORD_LEFT_SHIFT,
        OP_WORD_RIGHT_SHIFT,
        OP_DWORD_RIGHT_SHIFT,
        OP_SIGNED_WORD_RIGHT_SHIFT
    } op_t;

endpackage

/* File: hw/shift_op_if.sv */
// Carrier between the unit's control block and its operation datapath.
// Assumes both ends share one clock; the datapath is purely combinational.
`timescale 1ns/1ps
interface shift_op_if;
    import word_logic_shift_pkg::*;

    op_t op;
    logic [31:0] firstOperand;
    logic [31:0] secondOperand;
    logic [15:0] shiftCount;
    logic [31:0] result;
    logic lastBit;
    logic nonzeroUpdate;
    logic zeroClear;
    logic tooLargeClear;
    logic isLogicOp;

    modport ctrl (
        output op,
        output firstOperand,
        output secondOperand,
        output shiftCount,
        input result,
        input lastBit,
        input nonzeroUpdate,
        input zeroClear,
        input tooLargeClear,
        input isLogicOp
    );

    modport unit (
        input op,
        input firstOperand,
        input secondOperand,
        input shiftCount,
        output result,
        output lastBit,
        output nonzeroUpdate,
        output zeroClear,
        output tooLargeClear,
        output isLogicOp
    );
endinterface

/* File: hw/word_logic_shift_datapath.sv */
// Combinational datapath: exclusive combine and the five shift kinds.
// Assumes the control block registers everything it produces.
`timescale 1ns/1ps
`include "word_logic_shift_cfg.svh"
module word_logic_shift_datapath (
    shift_op_if.unit opPort
);
    import word_logic_shift_pkg::*;

    logic [31:0] leftWord;
    logic [63:0] leftDword;
    logic [31:0] rightWord;
    logic [63:0] rightDword;
    logic signed [31:0] signedRight;
    logic [4:0] clampedCount;
    logic [31:0] combined;
    logic countNonzero;

    // ------------------------------------------------------------------
    // Shifters
    // ------------------------------------------------------------------
    // Operands sit in a zero-extended window so the last bit moved out
    // lands in a fixed position and large counts give zero by themselves
    always_comb
    begin
        combined = opPort.firstOperand ^ opPort.secondOperand;
        countNonzero = (opPort.shiftCount != `WLS_RESET_COUNT);
        leftWord = {16'h0000, opPort.firstOperand[15:0]} << opPort.shiftCount;
        leftDword = {32'h0000_0000, opPort.firstOperand} << opPort.shiftCount;
        rightWord = {opPort.firstOperand[15:0], 16'h0000} >> opPort.shiftCount;
        rightDword = {opPort.firstOperand, 32'h0000_0000} >> opPort.shiftCount;
        // Counts above sixteen act as sixteen
        if (opPort.shiftCount > `WLS_WORD_BITS)
        begin
            clampedCount = `WLS_WORD_CLAMP;
        end
        else
        begin
            clampedCount = opPort.shiftCount[4:0];
        end
        signedRight = $signed({opPort.firstOperand[15:0], 16'h0000}) >>> clampedCount;
    end

    // ------------------------------------------------------------------
    // Result and status effects per operation
    // ------------------------------------------------------------------
    // A zero count moves no bit, so a shift then leaves the nonzero bit alone
    always_comb
    begin
        opPort.result = opPort.firstOperand;
        opPort.lastBit = 1'b0;
        opPort.nonzeroUpdate = 1'b0;
        opPort.zeroClear = 1'b0;
        opPort.tooLargeClear = 1'b0;
        opPort.isLogicOp = 1'b0;
        case (opPort.op)
            OP_DWORD_EXCLUSIVE_COMBINE:
            begin
                opPort.result = combined;
                opPort.lastBit = (combined != `WLS_RESET_WORD);
                opPort.nonzeroUpdate = 1'b1;
                opPort.zeroClear = 1'b1;
                opPort.tooLargeClear = 1'b1;
                opPort.isLogicOp = 1'b1;
            end
            OP_WORD_LEFT_SHIFT:
            begin
                opPort.result = {opPort.firstOperand[31:16], leftWord[15:0]};
                opPort.lastBit = leftWord[16];
                opPort.nonzeroUpdate = countNonzero;
                opPort.zeroClear = 1'b1;
                opPort.tooLargeClear = 1'b1;
            end
            OP_DWORD_LEFT_SHIFT:
            begin
                opPort.result = leftDword[31:0];
                opPort.lastBit = leftDword[32];
                opPort.nonzeroUpdate = countNonzero;
                opPort.zeroClear = countNonzero;
                opPort.tooLargeClear = countNonzero;
            end
            OP_WORD_RIGHT_SHIFT:
            begin
                opPort.result = {opPort.firstOperand[31:16], rightWord[31:16]};
                opPort.lastBit = rightWord[15];
                opPort.nonzeroUpdate = countNonzero;
                opPort.zeroClear = (opPort.shiftCount > `WLS_WORD_BITS);
                opPort.tooLargeClear = 1'b1;
            end
            OP_DWORD_RIGHT_SHIFT:
            begin
                opPort.result = rightDword[63:32];
                opPort.lastBit = rightDword[31];
                opPort.nonzeroUpdate = countNonzero;
                opPort.zeroClear = (opPort.shiftCount > `WLS_DWORD_BITS);
                opPort.tooLargeClear = 1'b1;
            end
            OP_SIGNED_WORD_RIGHT_SHIFT:
            begin
                opPort.result = {opPort.firstOperand[31:16], signedRight[31:16]};
                opPort.lastBit = signedRight[15];
                opPort.nonzeroUpdate = countNonzero;
                opPort.zeroClear = 1'b1;
                opPort.tooLargeClear = 1'b1;
            end
            default:
            begin
                opPort.result = opPort.firstOperand;
            end
        endcase
    end
endmodule

/* File: hw/word_logic_shift_unit.sv */
// Word logic and shift unit: APB register slave, enable sequencing,
// status word and cascade enable output.
// Assumes one 100 MHz clock, synchronous active-low reset, APB master.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "word_logic_shift_cfg.svh"
module word_logic_shift_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`WLS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] result,
    output logic cascadeEnableOut,
    output logic nonzeroCondition,
    output logic zeroCondition,
    output logic resultTooLarge,
    output logic logicResult,
    output word_logic_shift_pkg::op_t activeOp
);
    import word_logic_shift_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    shift_op_if opBus ();

    logic [31:0] firstOperand;
    logic [31:0] secondOperand;
    logic [15:0] shiftCount;
    logic enable;
    logic lastCascade;
    logic writeDone;
    logic setupPhase;
    logic addrMapped;
    logic opCodeValid;
    logic next_nonzero;
    logic [31:0] readValue;
    logic [31:0] statusWord;

    word_logic_shift_datapath datapath (
        .opPort(opBus.unit)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Access completes at the edge where pready is sampled high; no wait
    // state is added, prdata and pready come from flip-flops loaded in the setup phase
    assign setupPhase = psel && !penable && !pready;
    assign writeDone = psel && penable && pready && pwrite;
    assign opCodeValid = (pwdata[`WLS_CTRL_OP_LSB +: `WLS_CTRL_OP_W]
                          <= OP_SIGNED_WORD_RIGHT_SHIFT);

    // Unmapped offsets and writes to read-only words answer with an error
    always_comb
    begin
        addrMapped = 1'b1;
        readValue = `WLS_RESET_WORD;
        case (paddr)
            `WLS_OFF_FIRST: readValue = firstOperand;
            `WLS_OFF_SECOND: readValue = secondOperand;
            `WLS_OFF_COUNT: readValue = {16'h0000, shiftCount};
            `WLS_OFF_CTRL: readValue = {29'h0000_0000, activeOp};
            `WLS_OFF_RESULT: readValue = result;
            `WLS_OFF_STATUS: readValue = statusWord;
            default: addrMapped = 1'b0;
        endcase
    end

    assign statusWord = {27'h0000_000, logicResult, resultTooLarge,
                         nonzeroCondition, zeroCondition, lastCascade};

    // Bus answer flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `WLS_RESET_WORD;
        end
        else
        begin
            pready <= setupPhase;
            pslverr <= setupPhase && (!addrMapped || (pwrite
                       && (paddr == `WLS_OFF_RESULT || paddr == `WLS_OFF_STATUS)));
            prdata <= (setupPhase && !pwrite) ? readValue : `WLS_RESET_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Operand and control registers
    // ------------------------------------------------------------------
    // Byte strobes apply to operand words; count takes its low two lanes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            firstOperand <= `WLS_RESET_WORD;
            secondOperand <= `WLS_RESET_WORD;
            shiftCount <= `WLS_RESET_COUNT;
        end
        else if (writeDone)
        begin
            for (int lane = 0; lane < 4; lane++)
            begin
                if (pstrb[lane] && paddr == `WLS_OFF_FIRST)
                begin
                    firstOperand[lane*8 +: 8] <= pwdata[lane*8 +: 8];
                end
                if (pstrb[lane] && paddr == `WLS_OFF_SECOND)
                begin
                    secondOperand[lane*8 +: 8] <= pwdata[lane*8 +: 8];
                end
                if (pstrb[lane] && lane < 2 && paddr == `WLS_OFF_COUNT)
                begin
                    shiftCount[lane*8 +: 8] <= pwdata[lane*8 +: 8];
                end
            end
        end
    end

    // Operation select and the one-cycle enable pulse; a bad code is
    // dropped whole so a stray write never launches a wrong operation
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            activeOp <= OP_DWORD_EXCLUSIVE_COMBINE;
            enable <= 1'b0;
        end
        else
        begin
            enable <= 1'b0;
            if (writeDone && paddr == `WLS_OFF_CTRL && pstrb[0] && opCodeValid)
            begin
                activeOp <= op_t'(pwdata[`WLS_CTRL_OP_LSB +: `WLS_CTRL_OP_W]);
                enable <= pstrb[1] && pwdata[`WLS_CTRL_EXEC_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Datapath hookup
    // ------------------------------------------------------------------
    assign opBus.op = activeOp;
    assign opBus.firstOperand = firstOperand;
    assign opBus.secondOperand = secondOperand;
    assign opBus.shiftCount = shiftCount;
    assign next_nonzero = opBus.nonzeroUpdate ? opBus.lastBit : nonzeroCondition;

    // ------------------------------------------------------------------
    // Result and status word
    // ------------------------------------------------------------------
    // Whole update lands at the edge after enable is seen high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            result <= `WLS_RESET_WORD;
            nonzeroCondition <= 1'b0;
            zeroCondition <= 1'b0;
            resultTooLarge <= 1'b0;
            logicResult <= 1'b0;
        end
        else if (enable)
        begin
            result <= opBus.result;
            nonzeroCondition <= next_nonzero;
            if (opBus.zeroClear)
            begin
                zeroCondition <= 1'b0;
            end
            if (opBus.tooLargeClear)
            begin
                resultTooLarge <= 1'b0;
            end
            logicResult <= opBus.isLogicOp ? 1'b1 : next_nonzero;
        end
    end

    // Cascade output pulses with each combine and each shift that leaves the nonzero bit set, and is low otherwise;
    // software sees the last value in the status word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cascadeEnableOut <= 1'b0;
            lastCascade <= 1'b0;
        end
        else
        begin
            cascadeEnableOut <= enable && (opBus.isLogicOp || next_nonzero);
            if (enable)
            begin
                lastCascade <= opBus.isLogicOp || next_nonzero;
            end
        end
    end
endmodule

/* File: dv/word_logic_shift_unit_props.sv */
// Port-level properties of the word logic and shift unit.
// Assumes bind onto the unit top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "word_logic_shift_cfg.svh"
module word_logic_shift_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`WLS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] result,
    input wire logic cascadeEnableOut,
    input wire logic nonzeroCondition,
    input wire logic zeroCondition,
    input wire logic resultTooLarge,
    input wire logic logicResult,
    input wire word_logic_shift_pkg::op_t activeOp
);
    import word_logic_shift_pkg::*;

    logic ctrlWrite;
    logic ctrlExec;
    logic execD;

    // Completed CTRL write, and the part of it that launches an operation
    assign ctrlWrite = psel && penable && pready && pwrite && paddr == `WLS_OFF_CTRL;
    assign ctrlExec = ctrlWrite && pwdata[8] && pwdata[2:0] < 3'h6 && pstrb[1:0] == 2'h3;

    // Mirror of the enable flop; outputs move on the edge after it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            execD <= 1'b0;
        else
            execD <= ctrlExec;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    result_hold_a: assert property (!execD |=> $stable(result) && $stable(nonzeroCondition))
        else $error("result or nonzero bit moved without an operation");
    cascade_idle_a: assert property (!execD |=> !cascadeEnableOut)
        else $error("cascade output high without an operation");
    cascade_cause_a: assert property (cascadeEnableOut |-> $past(execD))
        else $error("cascade output not caused by an enabled write");
    xor_cascade_a: assert property (ctrlExec && pwdata[2:0] == 3'h0 |-> ##2 cascadeEnableOut)
        else $error("exclusive combine did not pass the enable on");
    xor_nonzero_a: assert property (execD && activeOp == OP_DWORD_EXCLUSIVE_COMBINE
        |=> logicResult && nonzeroCondition == (result != 32'h0000_0000))
        else $error("nonzero bit disagrees with combine result");
    shift_cascade_a: assert property (execD && activeOp != OP_DWORD_EXCLUSIVE_COMBINE
        |=> cascadeEnableOut == nonzeroCondition && logicResult == nonzeroCondition)
        else $error("shift cascade, nonzero and logic bits differ");
    zero_clear_a: assert property (!zeroCondition)
        else $error("zero condition bit set");
    too_large_a: assert property (!resultTooLarge)
        else $error("too large bit set");
    refused_code_a: assert property (ctrlWrite && pwdata[2:0] > 3'h5 |=> $stable(activeOp))
        else $error("refused operation code was taken");
endmodule

bind word_logic_shift_unit word_logic_shift_checker word_logic_shift_checker_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result(result), .cascadeEnableOut(cascadeEnableOut),
    .nonzeroCondition(nonzeroCondition), .zeroCondition(zeroCondition),
    .resultTooLarge(resultTooLarge), .logicResult(logicResult), .activeOp(activeOp));

/* File: dv/apb_sequencer_model.sv */
// Program sequencer model: APB master feeding operands, count and control.
// Assumes the unit answers every transfer with pready; waits without a bound.
`timescale 1ns/1ps
`include "word_logic_shift_cfg.svh"
module apb_sequencer_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`WLS_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
    end

    // One transfer; an idle edge first so no signal is assigned twice per step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd; // Released data must not look stale
    endtask
endmodule

/* File: dv/word_logic_shift_unit_tb.sv */
// Self-checking bench of the word logic and shift unit.
// Assumes the sequencer model as APB master and the bound checker.
`timescale 1ns/1ps
`include "word_logic_shift_cfg.svh"
module word_logic_shift_unit_tb;
    import word_logic_shift_pkg::*;
    typedef struct {logic [31:0] res; logic casc; logic nz; logic lg; logic [2:0] op;} exp_t;

    logic clk;
    logic rst_n;
    logic psel, penable, pwrite, pslverr, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, result, rd;
    logic [3:0] pstrb;
    logic cascadeEnableOut, nonzeroCondition, zeroCondition, resultTooLarge, logicResult;
    logic err;
    op_t activeOp;
    int seed = 99187;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int cnt[8] = '{0, 1, 15, 16, 17, 31, 32, 33};
    exp_t expQ[$];
    exp_t ex;
    logic [31:0] expRes = 32'h0000_0000;
    logic expNz = 1'b0;
    logic expLg = 1'b0;
    logic [2:0] expOp = 3'h0;

    word_logic_shift_unit word_logic_shift_unit_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .result(result),
        .cascadeEnableOut(cascadeEnableOut), .nonzeroCondition(nonzeroCondition),
        .zeroCondition(zeroCondition), .resultTooLarge(resultTooLarge),
        .logicResult(logicResult), .activeOp(activeOp));
    apb_sequencer_model apb_sequencer_model_i (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task readCheck(input logic [11:0] a, input logic [31:0] ed, input logic ee);
        apb_sequencer_model_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
        check("read data", ed, rd);
        check("bus error", {31'h0, ee}, {31'h0, err});
    endtask

    // Model one CTRL write and note what the outputs must show after it
    task runOp(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
        input logic [15:0] n, input logic go);
        logic [31:0] r;
        logic [31:0] t;
        logic last;
        int m;
        int w;
        r = expRes;
        last = expNz;
        m = n;
        w = (op == 3'h2 || op == 3'h4) ? 32 : 16;
        if (op == 3'h5 && m > 16)
            m = 16;
        t = {{16{a[15]}}, a[15:0]} >> m;
        if (go && op < 3'h6)
        begin
            case (op)
                3'h0: r = a ^ b;
                3'h1: r = {a[31:16], a[15:0] << m};
                3'h2: r = a << m;
                3'h3: r = {a[31:16], a[15:0] >> m};
                3'h4: r = a >> m;
                default: r = {a[31:16], t[15:0]};
            endcase
            if (op != 3'h0 && m > 0)
                last = (m > w) ? 1'b0 : ((op < 3'h3) ? a[w - m] : a[m - 1]);
            expNz = (op == 3'h0) ? (r != 32'h0000_0000) : last;
            expLg = (op == 3'h0) ? 1'b1 : last;
        end
        // Refused codes leave the selected operation as it was
        if (op < 3'h6)
            expOp = op;
        expQ.push_back('{r, go && op < 3'h6 && (op == 3'h0 || expNz), expNz, expLg, expOp});
        expRes = r;
        apb_sequencer_model_i.xfer(1'b1, `WLS_OFF_FIRST, a, rd, err);
        apb_sequencer_model_i.xfer(1'b1, `WLS_OFF_SECOND, b, rd, err);
        apb_sequencer_model_i.xfer(1'b1, `WLS_OFF_COUNT, {16'h0000, n}, rd, err);
        apb_sequencer_model_i.xfer(1'b1, `WLS_OFF_CTRL, {23'h0, go, 5'h00, op}, rd, err);
    endtask

    task end_of_test();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, timeout and output watcher
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Generous ceiling; the whole run needs under two thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // Outputs settle on the edge after the CTRL write completes
    always @(posedge clk)
    begin
        if (psel && penable && pready && pwrite && paddr == `WLS_OFF_CTRL)
        begin
            @(posedge clk);
            #1;
            ex = expQ.pop_front();
            check("result", ex.res, result);
            check("nonzero", {31'h0, ex.nz}, {31'h0, nonzeroCondition});
            check("cascade", {31'h0, ex.casc}, {31'h0, cascadeEnableOut});
            check("logic result", {31'h0, ex.lg}, {31'h0, logicResult});
            check("zero cond", 32'h0000_0000, {31'h0, zeroCondition});
            check("too large", 32'h0000_0000, {31'h0, resultTooLarge});
            check("active op", {29'h0, ex.op}, {29'h0, activeOp});
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++)
            readCheck(12'(i * 4), 32'h0000_0000, 1'b0);
        readCheck(12'h018, 32'h0000_0000, 1'b1);
        apb_sequencer_model_i.xfer(1'b1, `WLS_OFF_RESULT, 32'h1234_5678, rd, err);
        check("bus error", 32'h0000_0001, {31'h0, err});
        readCheck(`WLS_OFF_RESULT, 32'h0000_0000, 1'b0);
        runOp(3'h0, 32'h1234_5678, 32'h0f0f_f0f0, 16'h0003, 1'b1);
        runOp(3'h0, 32'ha5a5_0f0f, 32'ha5a5_0f0f, 16'h0000, 1'b1);
        // Every shift kind at the count boundaries
        for (int op = 1; op < 6; op++)
            for (int k = 0; k < 8; k++)
                runOp(3'(op), $random(seed), 32'h0000_0000, 16'(cnt[k]), 1'b1);
        runOp(3'h5, 32'h0000_8001, 32'h0000_0000, 16'h0004, 1'b1);
        runOp(3'h1, 32'hffff_ffff, 32'h0000_0000, 16'h0003, 1'b0);
        runOp(3'h6, 32'hffff_ffff, 32'h0000_0001, 16'h0001, 1'b1);
        runOp(3'h7, 32'hffff_ffff, 32'h0000_0001, 16'h0001, 1'b1);
        repeat (40)
            runOp(3'($unsigned($random(seed)) % 6), $random(seed), $random(seed),
                16'($unsigned($random(seed)) % 40), 1'b1);
        readCheck(`WLS_OFF_RESULT, expRes, 1'b0);
        apb_sequencer_model_i.xfer(1'b0, `WLS_OFF_STATUS, 32'h0000_0000, rd, err);
        check("status", {27'h0, expLg, 1'b0, expNz, 1'b0, ex.casc}, rd);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule
